/* File: lvds_rx_defines.svh */
`ifndef LVDS_RX_DEFINES_SVH
`define LVDS_RX_DEFINES_SVH
// Overview of operation
// - Every data bus crossing between clock domains passes through a FIFO.
// - Cable data is written into its FIFO on the clock forwarded with it.
// - FIFO read side runs on the local PLL clock locked to the 10MHz reference.
// - Four cables, each carrying two antenna streams, so eight receive paths.
// - After crossing, outputs launch directly on the shared local clock, no FIFO.
// - Misalignment is measurable and a storable delay setting is held and reapplied.
// - Local clocks come straight from the reference PLL, never by halving outside it.

// Receive structure.
`define CABLES        4
`define STREAMS       2
`define PATHS         8
`define SAMPLE_W      16
`define FIFO_AW       3
`define FIFO_DEPTH    8
`define DELAY_W       4
`define DELAY_RST     4'h4
`endif

/* File: lvds_rx_pkg.sv */
`include "lvds_rx_defines.svh"
package lvds_rx_pkg;
   typedef logic [`FIFO_AW:0]    ptr_t;
   typedef logic [`SAMPLE_W-1:0] sample_t;
   typedef logic [`DELAY_W-1:0]  delay_t;
   typedef enum logic {ALIGN, STREAM} rd_mode_t;

   // Binary to Gray, so that only one pointer bit moves per step.
   function automatic ptr_t bin2gray(input ptr_t b);
      return b ^ (b >> 1);
   endfunction

   // Gray back to binary for occupancy arithmetic.
   function automatic ptr_t gray2bin(input ptr_t g);
      ptr_t b;
      b = g;
      for (int i = `FIFO_AW - 1; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction
endpackage

/* File: rx_fifo_if.sv */
interface rx_fifo_if
   import lvds_rx_pkg::*;
();
   logic    rd_en;
   sample_t rd_data;
   ptr_t    level;
   logic    empty;
   logic    ovf;

   modport fifo_rd (input rd_en, output rd_data, output level, output empty, output ovf);
   modport user    (output rd_en, input rd_data, input level, input empty, input ovf);
endinterface

/* File: rx_async_fifo.sv */
module rx_async_fifo
   import lvds_rx_pkg::*;
(
   // Forwarded link clock and the data that travels with it.
   input  wire logic    wclk,
   input  wire logic    wr_valid,
   input  wire sample_t wr_data,
   // Local clock domain.
   input  wire logic    clk,
   input  wire logic    rst,
   rx_fifo_if.fifo_rd   rd
);
   typedef struct packed {
      logic rst_m;
      logic rst_s;
      ptr_t wbin;
      ptr_t wgray;
      ptr_t rg_m;
      ptr_t rg_s;
      logic ovf;
   } wr_state_t;

   typedef struct packed {
      ptr_t rbin;
      ptr_t rgray;
      ptr_t wg_m;
      ptr_t wg_s;
      logic ovf_m;
      logic ovf_s;
   } rd_state_t;

   wr_state_t ws_q, ws_d;
   rd_state_t rs_q, rs_d;
   sample_t   mem [`FIFO_DEPTH];
   logic      full;
   logic      push;
   ptr_t      wbin_nx;

   // Write side on the forwarded clock; reset arrives through two flops.
   always_comb
   begin
      ws_d       = ws_q;
      ws_d.rst_m = rst;
      ws_d.rst_s = ws_q.rst_m;
      ws_d.rg_m  = rs_q.rgray;
      ws_d.rg_s  = ws_q.rg_m;
      full       = ws_q.wgray == {~ws_q.rg_s[`FIFO_AW:`FIFO_AW-1], ws_q.rg_s[`FIFO_AW-2:0]};
      push       = wr_valid && !full;
      wbin_nx    = ws_q.wbin + ptr_t'(1);
      if (push)
      begin
         ws_d.wbin  = wbin_nx;
         ws_d.wgray = bin2gray(wbin_nx);
      end
      // Overflow stays set until reset, so no clear can race an event.
      if (wr_valid && full)
      begin
         ws_d.ovf = 1'b1;
      end
      if (ws_q.rst_s)
      begin
         ws_d.wbin  = '0;
         ws_d.wgray = '0;
         ws_d.ovf   = 1'b0;
      end
   end

   always_ff @(posedge wclk)
   begin
      ws_q <= ws_d;
   end

   // Storage is written only on the link clock.
   always_ff @(posedge wclk)
   begin
      if (push && !ws_q.rst_s)
      begin
         mem[ws_q.wbin[`FIFO_AW-1:0]] <= wr_data;
      end
   end

   // Read side on the local clock.
   always_comb
   begin
      rs_d       = rs_q;
      rs_d.wg_m  = ws_q.wgray;
      rs_d.wg_s  = rs_q.wg_m;
      rs_d.ovf_m = ws_q.ovf;
      rs_d.ovf_s = rs_q.ovf_m;
      if (rd.rd_en && !rd.empty)
      begin
         rs_d.rbin  = rs_q.rbin + ptr_t'(1);
         rs_d.rgray = bin2gray(rs_d.rbin);
      end
      if (rst)
      begin
         rs_d = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      rs_q <= rs_d;
   end

   // Occupancy and empty use only the second synchroniser stage.
   assign rd.level   = gray2bin(rs_q.wg_s) - rs_q.rbin;
   assign rd.empty   = rs_q.wg_s == rs_q.rgray;
   assign rd.rd_data = mem[rs_q.rbin[`FIFO_AW-1:0]];
   assign rd.ovf     = rs_q.ovf_s;
endmodule // rx_async_fifo

/* File: lvds_rx_crossing.sv */
module lvds_rx_crossing
   import lvds_rx_pkg::*;
(
   // Local clock from the reference-locked PLL, and its reset.
   input  wire logic                   clk,
   input  wire logic                   rst,
   // One forwarded clock per cable.
   input  wire logic [`CABLES-1:0]     link_clk,
   // Per path: link valid and sample, path index is cable*2+stream.
   input  wire logic [`PATHS-1:0]      link_valid,
   input  wire sample_t [`PATHS-1:0]   link_data,
   // Delay correction load, one strobe per path.
   input  wire logic [`PATHS-1:0]      delay_load,
   input  wire delay_t                 delay_in,
   // Aligned samples on the local clock.
   output logic [`PATHS-1:0]           out_valid,
   output sample_t [`PATHS-1:0]        out_data,
   // Measurement and status.
   output ptr_t [`PATHS-1:0]           fill_level,
   output ptr_t [`PATHS-1:0]           align_level,
   output delay_t [`PATHS-1:0]         delay_held,
   output logic [`PATHS-1:0]           locked,
   output logic [`PATHS-1:0]           underrun,
   output logic [`PATHS-1:0]           overflow
);
   // Registered state of all eight paths. Every output of the block is one field of it, so nothing
   // combinational reaches a pin, and the read enable of each FIFO comes from its mode field and the FIFO's empty flag.
   typedef struct packed {
      // Read mode per path: filling up to the delay, or streaming out.
      rd_mode_t [`PATHS-1:0] mode;
      // Delivered sample and its one-cycle strobe; the sample holds between strobes.
      logic     [`PATHS-1:0] valid;
      sample_t  [`PATHS-1:0] data;
      // Skew measurement: occupancy seen each cycle, and occupancy captured at lock.
      ptr_t     [`PATHS-1:0] fill;
      ptr_t     [`PATHS-1:0] align;
      // Delay correction in force; software stores it and reloads it after a power cycle.
      delay_t   [`PATHS-1:0] delay;
      // Status flags. Lock mirrors the mode; the two error flags stay set until reset.
      logic     [`PATHS-1:0] lock;
      logic     [`PATHS-1:0] udr;
      logic     [`PATHS-1:0] ovf;
   } top_state_t;

   top_state_t st_q, st_d;
   // Per-path wires between the FIFOs and the local state.
   logic       [`PATHS-1:0] rd_en;
   logic       [`PATHS-1:0] empty_w;
   logic       [`PATHS-1:0] ovf_w;
   sample_t    [`PATHS-1:0] rdata_w;
   ptr_t       [`PATHS-1:0] level_w;

   // Eight receive FIFOs, two per cable; both streams of a cable share its forwarded clock.
   // Path j belongs to cable j/2 and stream j%2, the order in which the senders pack a cable.
   // Each FIFO keeps its link side entirely on the forwarded clock, so the cable skew, whatever
   // it is, only shows up as a different fill depth on the local side.
   for (genvar j = 0; j < `PATHS; j++)
   begin : g_path
      rx_fifo_if fif ();

      rx_async_fifo u_fifo (
         .wclk     (link_clk[j / `STREAMS]),
         .wr_valid (link_valid[j]),
         .wr_data  (link_data[j]),
         .clk      (clk),
         .rst      (rst),
         .rd       (fif.fifo_rd)
      );

      assign fif.rd_en  = rd_en[j];
      assign empty_w[j] = fif.empty;
      assign ovf_w[j]   = fif.ovf;
      assign rdata_w[j] = fif.rd_data;
      assign level_w[j] = fif.level;
   end

   // A path reads only once running and while data is present. Reading in the same cycle as the
   // empty test is safe because empty comes from registered pointers only; the write pointer it
   // compares against is at least two local edges old, which can only make the FIFO look emptier
   // than it is, never fuller.
   always_comb
   begin
      for (int j = 0; j < `PATHS; j++)
      begin
         rd_en[j] = (st_q.mode[j] == STREAM) && !empty_w[j];
      end
   end

   // Per path: hold off until the FIFO has filled to the delay setting, then stream.
   // Starting at a chosen fill depth turns the stored delay into a fixed skew correction.
   // The local clock is much faster than a link, so a streaming path drains its FIFO and drops
   // back to filling after every burst; each refill starts again at the same depth, so the first word of a
   // refill waits for delay-1 further link words plus the crossing, and the last word for the crossing alone.
   // Limitation: the write side learns of reads two link edges late, so a setting above six can
   // still see the FIFO as full while it is being emptied and lose words, and a setting above
   // eight can never be reached, which leaves the path unlocked.
   // Loading a new delay always restarts alignment, so it takes effect at the next fill.
   always_comb
   begin
      st_d = st_q;
      for (int j = 0; j < `PATHS; j++)
      begin
         st_d.fill[j]  = level_w[j];
         st_d.valid[j] = rd_en[j];
         st_d.data[j]  = rd_en[j] ? rdata_w[j] : st_q.data[j];
         st_d.ovf[j]   = st_q.ovf[j] | ovf_w[j];
         if (delay_load[j])
         begin
            st_d.delay[j] = delay_in;
            st_d.mode[j]  = ALIGN;
         end
         else
         begin
            unique case (st_q.mode[j])
               ALIGN:
               begin
                  if (level_w[j] >= ptr_t'(st_q.delay[j]))
                  begin
                     st_d.mode[j]  = STREAM;
                     st_d.align[j] = level_w[j];
                  end
               end
               STREAM:
               begin
                  // Running dry ends every refill, since reads outpace writes; realign and flag it.
                  if (empty_w[j])
                  begin
                     st_d.mode[j] = ALIGN;
                     st_d.udr[j]  = 1'b1;
                  end
               end
            endcase
         end
         // Lock is registered from the next mode so that its pin is driven from a flop.
         st_d.lock[j] = st_d.mode[j] == STREAM;
      end
      // Reset parks every path in alignment at the default delay and clears both flags.
      if (rst)
      begin
         st_d = '0;
         for (int j = 0; j < `PATHS; j++)
         begin
            st_d.mode[j]  = ALIGN;
            st_d.delay[j] = `DELAY_RST;
         end
      end
   end

   // All local logic runs on the reference-locked clock; no divided copies are made here.
   // A slower local rate, where needed, must come from its own PLL output rather than from a
   // divider on this clock, since a divider would start in an unknown phase after each reset.
   always_ff @(posedge clk)
   begin
      st_q <= st_d;
   end

   // Delivered samples: one strobe per word, the sample held in between.
   assign out_valid   = st_q.valid;
   assign out_data    = st_q.data;
   // Measurement: live fill and the fill captured when the path last locked.
   assign fill_level  = st_q.fill;
   assign align_level = st_q.align;
   // Correction in force and status, all straight from the state register.
   assign delay_held  = st_q.delay;
   assign locked      = st_q.lock;
   assign underrun    = st_q.udr;
   assign overflow    = st_q.ovf;
endmodule // lvds_rx_crossing

/* File: lvds_rx_sender.sv */
module lvds_rx_sender
   import lvds_rx_pkg::*;
#(
   parameter logic [2:0] TAG   = 3'h0,
   parameter realtime    PHASE = 1.3
)
(
   // Frame control from the bench.
   input  wire logic     run,
   input  wire logic     send,
   // Cable: forwarded clock and two streams.
   output logic          lclk,
   output logic [1:0]    valid = 2'h0,
   output sample_t [1:0] data  = '1
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0] cnt = 12'h000;

   // The forwarded clock stands still low whenever no frame runs.
   initial
   begin
      lclk = 1'b0;
      #(PHASE);
      forever
      begin
         #80;
         lclk = run ? ~lclk : 1'b0;
      end
   end

   // Launch on the falling edge; idle lines invert so stale data cannot pass.
   always @(negedge lclk)
   begin
      valid = {2{send}};
      for (int s = 0; s < 2; s++)
         data[s] = send ? {TAG, 1'(s), cnt} : ~data[s];
      cnt = cnt + 12'(send);
   end
endmodule // lvds_rx_sender

/* File: lvds_rx_crossing_asserts.sv */
module lvds_rx_crossing_asserts
   import lvds_rx_pkg::*;
(
   // Local clock, reset and local-side signals.
   input wire logic                 clk,
   input wire logic                 rst,
   input wire logic [`PATHS-1:0]    delay_load,
   input wire delay_t               delay_in,
   input wire logic [`PATHS-1:0]    out_valid,
   input wire sample_t [`PATHS-1:0] out_data,
   input wire ptr_t [`PATHS-1:0]    fill_level,
   input wire ptr_t [`PATHS-1:0]    align_level,
   input wire delay_t [`PATHS-1:0]  delay_held,
   input wire logic [`PATHS-1:0]    locked,
   input wire logic [`PATHS-1:0]    underrun,
   input wire logic [`PATHS-1:0]    overflow
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // The reset and sticky-flag checks cover all paths; the rest use path 0 for the others, which share one body.
   a_delay_take: assert property (delay_load[0] |=> delay_held[0] == $past(delay_in) && !locked[0])
      else $error("delay load not applied");
   a_reset_value: assert property ($fell(rst) |-> delay_held == {`PATHS{`DELAY_RST}} && locked == '0)
      else $error("bad state after reset");
   a_lock_level: assert property ($rose(locked[0]) |-> align_level[0] >= delay_held[0])
      else $error("locked below delay");
   a_out_locked: assert property (out_valid[0] |-> $past(locked[0]))
      else $error("output while aligning");
   a_data_hold: assert property ($changed(out_data[0]) |-> out_valid[0])
      else $error("data moved without valid");
   a_fill_max: assert property (fill_level[0] <= `FIFO_DEPTH)
      else $error("fill above depth");
   a_overflow_sticky: assert property ((overflow & $past(overflow)) == $past(overflow))
      else $error("overflow cleared");
   a_underrun_sticky: assert property ((underrun & $past(underrun)) == $past(underrun))
      else $error("underrun cleared");
endmodule // lvds_rx_crossing_asserts

bind lvds_rx_crossing lvds_rx_crossing_asserts i_asserts (.clk(clk), .rst(rst), .delay_load(delay_load),
   .delay_in(delay_in), .out_valid(out_valid), .out_data(out_data), .fill_level(fill_level),
   .align_level(align_level), .delay_held(delay_held), .locked(locked), .underrun(underrun),
   .overflow(overflow));

/* File: lvds_receive_domain_crossing_bench.sv */
module lvds_receive_domain_crossing_bench
   import lvds_rx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  clk = 1'b0, rst = 1'b1, run = 1'b1, send = 1'b0;
   logic [`CABLES-1:0]    link_clk;
   logic [`PATHS-1:0]     link_valid, delay_load = '0, out_valid, locked, underrun, overflow;
   sample_t [`PATHS-1:0]  link_data, out_data;
   ptr_t [`PATHS-1:0]     fill_level, align_level;
   delay_t [`PATHS-1:0]   delay_held;
   delay_t                delay_in = '0;
   int                    n_errors = 0, checks = 0;
   int                    recv [`PATHS] = '{default: 0};
   delay_t                dly [`PATHS] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'hF};

   lvds_rx_crossing i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .link_valid(link_valid),
      .link_data(link_data), .delay_load(delay_load), .delay_in(delay_in), .out_valid(out_valid),
      .out_data(out_data), .fill_level(fill_level), .align_level(align_level), .delay_held(delay_held),
      .locked(locked), .underrun(underrun), .overflow(overflow));

   // One sender per cable, each at its own phase against the local clock.
   for (genvar c = 0; c < `CABLES; c++)
   begin : g_cable
      lvds_rx_sender #(.TAG(3'(c)), .PHASE(1.3 + 7.1 * c)) i_send (.run(run), .send(send),
         .lclk(link_clk[c]), .valid(link_valid[2*c+:2]), .data(link_data[2*c+:2]));
   end

   // Local clock at 200 MHz.
   always #2.5 clk = ~clk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Every word delivered must be the next one its sender launched on that path.
   always @(negedge clk)
   begin
      for (int j = 0; j < `PATHS; j++)
         if (!rst && out_valid[j] === 1'b1)
         begin
            check("out_data", out_data[j], {4'(j), 12'(recv[j])});
            recv[j]++;
         end
   end

   // Load a delay per path: six is the deepest that loses no words, fifteen is unreachable.
   task automatic t_delays();
      for (int j = 0; j < `PATHS; j++)
      begin
         delay_in = dly[j];
         delay_load = 8'h01 << j;
         @(negedge clk);
         delay_load = '0;
         check("delay_held", delay_held[j], dly[j]);
      end
   endtask

   // Twenty words on cable 0 and nineteen on cables 1 to 3, whose edges trail it; reads outpace writes, so streaming paths run dry.
   task automatic t_stream();
      send = 1'b1;
      repeat (20) @(negedge link_clk[0]);
      @(negedge clk);
      send = 1'b0;
      repeat (3) @(negedge link_clk[0]);
      run = 1'b0;
      repeat (40) @(negedge clk);
      check("recv", recv[0], 20);
      check("overflow", overflow, 8'h80);
      check("underrun", underrun, 8'h7F);
      check("locked", locked[7], 1'b0);
      check("fill_level", fill_level[7], 4'h8);
      for (int j = 0; j < 7; j++)
         check("align_level", align_level[j], dly[j]);
   endtask

   // Reset spans several link edges so it reaches every write side.
   initial
   begin
      repeat (12) @(negedge link_clk[0]);
      @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge link_clk[0]);
      @(negedge clk);
      check("delay_held", delay_held, {`PATHS{`DELAY_RST}});
      t_delays();
      t_stream();
      stop_test();
   end

   // The run needs under 10 us; this only trips on a hang.
   initial
   begin
      #50000;
      n_errors++;
      stop_test();
   end
endmodule // lvds_receive_domain_crossing_bench
